// ===== bench/rtc_link_chk.sv
// concurrent checks on the two-wire link between controller and alarm device
`timescale 1ns/1ps
module rtc_link_chk
   import rtc_link_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic host_scl,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   // ------------
   // link decoding
   // ------------
   logic prev_scl, prev_sda, first, wr_sel, rd_sel, foreign, done, rise, start_c, stop_c;
   logic [3:0] bit_idx;
   logic [7:0] shift, low_cnt;

   // conditions seen on the raw wires, in the same clock as the pins change
   assign rise = scl & ~prev_scl;
   assign start_c = scl & prev_scl & prev_sda & ~sda;
   assign stop_c = scl & prev_scl & ~prev_sda & sda;

   // track bit position, address match and direction of each transfer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
         bit_idx <= 4'h0;
         shift <= 8'h00;
         low_cnt <= 8'h00;
         first <= 1'b0;
         wr_sel <= 1'b0;
         rd_sel <= 1'b0;
         foreign <= 1'b0;
         done <= 1'b0;
      end else begin
         prev_scl <= scl;
         prev_sda <= sda;
         // saturate so a long idle low phase never wraps to a small count
         low_cnt <= scl ? 8'h00 : ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01);
         if (start_c || stop_c) begin
            bit_idx <= 4'h0;
            first <= start_c;
            wr_sel <= 1'b0;
            rd_sel <= 1'b0;
            foreign <= 1'b0;
            done <= 1'b0;
         end else if (rise) begin
            shift <= {shift[6:0], sda};
            if (bit_idx == 4'h8) begin
               bit_idx <= 4'h0;
               first <= 1'b0;
               if (first) begin
                  wr_sel <= (shift[7:1] == DEV_ADDR) && !shift[0];
                  rd_sel <= (shift[7:1] == DEV_ADDR) && shift[0];
                  foreign <= shift[7:1] != DEV_ADDR;
               end else if (rd_sel && sda) begin
                  done <= 1'b1;
               end
            end else begin
               bit_idx <= bit_idx + 4'h1;
            end
         end
      end
   end

   // ------------
   // properties
   // ------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_dev_change_low;
      $changed(dev_sda_oe) |-> !scl && (low_cnt <= 8'h0C);
   endproperty
   a_dev_change_low: assert property (p_dev_change_low)
      else $error("device changed data outside the clock low phase");
   property p_scl_high;
      $rose(host_scl) |-> host_scl [*8];
   endproperty
   a_scl_high: assert property (p_scl_high)
      else $error("clock high phase too short");
   property p_start_hold;
      $rose(host_sda_oe) && host_scl |-> !dev_sda_oe ##1 host_scl [*8];
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("start condition malformed");
   property p_stop_idle;
      $fell(host_sda_oe) && host_scl |-> ##1 (host_scl && sda) [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("bus not idle after stop");
   property p_rx_quiet;
      rise && (bit_idx < 4'h8) && !rd_sel |-> !dev_sda_oe;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet)
      else $error("device drove data while receiving");
   property p_addr_ack;
      rise && first && (bit_idx == 4'h8) |-> dev_sda_oe == (shift[7:1] == DEV_ADDR);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address acknowledge wrong");
   property p_write_ack;
      rise && !first && wr_sel && (bit_idx == 4'h8) |-> dev_sda_oe;
   endproperty
   a_write_ack: assert property (p_write_ack)
      else $error("written byte not acknowledged");
   property p_read_release;
      rise && rd_sel && (bit_idx == 4'h8) |-> !dev_sda_oe;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("device held data during master acknowledge");
   property p_foreign_quiet;
      foreign |-> !dev_sda_oe;
   endproperty
   a_foreign_quiet: assert property (p_foreign_quiet)
      else $error("device drove data for a foreign address");
   property p_nack_release;
      done |-> !dev_sda_oe;
   endproperty
   a_nack_release: assert property (p_nack_release)
      else $error("device kept sending after not-acknowledge");
endmodule : rtc_link_chk

// ===== bench/test_rtc_serial_slave_alarm_regs.sv
// self-checking bench: controller and alarm device joined over the two-wire link
`timescale 1ns/1ps
module test_rtc_serial_slave_alarm_regs
   import rtc_link_pkg::*;
;
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] val;
   } note_t;
   localparam logic [3:0] ST = 4'h1;
   localparam logic [3:0] SP = 4'h2;
   localparam logic [3:0] RD = 4'h4;
   localparam logic [3:0] NK = 4'h8;
   logic clk_i, rst_i, alarm_fire_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, alarm_flag_o, want;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd, r;
   logic [7:0] cur [4];
   logic [7:0] exp_reg [4];
   note_t notes [$];
   int fails, n_tests;

   rtc_link_if link_bus();
   rtc_alarm_slave u_rtc_alarm_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .alarm_fire_i(alarm_fire_i), .minute_match_o(cur[0]), .hour_match_o(cur[1]),
      .day_of_month_match_o(cur[2]), .weekday_match_o(cur[3]), .alarm_flag_o(alarm_flag_o),
      .link(link_bus));
   rtc_link_master u_rtc_link_master (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .link(link_bus));
   rtc_link_chk u_rtc_link_chk (.clk_i(clk_i), .rst_i(rst_i), .host_scl(link_bus.host_scl),
      .host_sda_oe(link_bus.host_sda_oe), .dev_sda_oe(link_bus.dev_sda_oe),
      .scl(link_bus.scl), .sda(link_bus.sda));

   // ------------
   // clock, compare and bus tasks
   // ------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic check_rd(input logic [31:0] got, input note_t n);
      n_tests++;
      if ((got & n.mask) !== n.val) begin
         fails++;
         $display("MISMATCH at %0t: bus read %h expected %h", $time, got & n.mask, n.val);
      end
   endtask : check_rd

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: output %h expected %h", $time, got, exp);
      end
   endtask : check_val

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic w, input note_t n);
      int k;
      if (w) notes.push_back(n);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      want <= w;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) fails++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      want <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // issue one link byte command, then poll until the controller is idle
   task automatic cmd(input logic [7:0] b, input logic [3:0] f);
      int k;
      wb(1'b1, CTL_CMD_ADR, {20'h0, f, b}, 1'b0, '0);
      k = 0;
      do begin
         wb(1'b0, CTL_STATUS_ADR, 32'h0, 1'b0, '0);
         k++;
      end while (rd[0] !== 1'b0 && k < 3000);
      if (k >= 3000) fails++;
   endtask : cmd

   task automatic stat(input logic [31:0] m, input logic [31:0] v);
      wb(1'b0, CTL_STATUS_ADR, 32'h0, 1'b1, '{m, v});
   endtask : stat

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // results appear at ack; the oldest note is the one due
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && want === 1'b1 && notes.size() > 0) begin
         check_rd(wb_dat_o, notes.pop_front());
      end
   end

   // the whole run needs about 115k cycles of link traffic
   initial begin
      repeat (130000) @(posedge clk_i);
      fails++;
      summarize();
   end

   // ------------
   // scenarios
   // ------------
   initial begin
      rst_i = 1'b1;
      alarm_fire_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      want = 1'b0;
      fails = 0;
      n_tests = 0;
      void'($urandom(19));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // device synchronisers need a few clocks before the bus moves
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 4; i++) check_val(cur[i], ALARM_RESET);
      check_val({7'h0, alarm_flag_o}, 8'h00);
      wb(1'b1, 8'h08, 32'hFFFF_FFFF, 1'b0, '0);
      wb(1'b0, 8'h08, 32'h0, 1'b1, '{32'hFFFF_FFFF, 32'h0});
      wb(1'b0, CTL_CMD_ADR, 32'h0, 1'b1, '{32'hFFFF_FFFF, 32'h0});
      $display("test reset_and_map done");
      // burst write of all four match registers from one pointer
      cmd(8'hA2, ST);
      cmd({4'h0, REG_MIN_ALARM}, 4'h0);
      stat(32'h2, 32'h0);
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         exp_reg[i] = r[7:0] & ALARM_MASK[i];
         cmd(r[7:0], (i == 3) ? SP : 4'h0);
         stat(32'h2, 32'h0);
      end
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 4; i++) check_val(cur[i], exp_reg[i]);
      $display("test burst_write done");
      // pointer then repeated start into a read of all four bytes
      cmd(8'hA2, ST);
      cmd({4'h0, REG_MIN_ALARM}, 4'h0);
      cmd(8'hA3, ST);
      for (int i = 0; i < 4; i++) begin
         cmd(8'h00, (i == 3) ? (RD | NK | SP) : RD);
         stat(32'h0000_FF00, {16'h0, exp_reg[i], 8'h00});
      end
      $display("test pointer_read done");
      // a foreign address is left unacknowledged
      cmd(8'hA4, ST | SP);
      stat(32'h2, 32'h2);
      $display("test foreign_address done");
      // alarm flag: set by hardware, write of one keeps it, write of zero clears it
      alarm_fire_i <= 1'b1;
      @(posedge clk_i);
      alarm_fire_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check_val({7'h0, alarm_flag_o}, 8'h01);
      // pointer set in its own transfer, then a read that reuses it
      cmd(8'hA2, ST);
      cmd({4'h0, REG_STATUS2}, SP);
      cmd(8'hA3, ST);
      cmd(8'h00, RD | NK | SP);
      stat(32'h0000_FF00, 32'h0000_0800);
      cmd(8'hA2, ST);
      cmd({4'h0, REG_STATUS2}, 4'h0);
      cmd(8'h08, 4'h0);
      check_val({7'h0, alarm_flag_o}, 8'h01);
      cmd(8'hA2, ST);
      cmd({4'h0, REG_STATUS2}, 4'h0);
      cmd(8'h00, SP);
      repeat (8) @(posedge clk_i);
      check_val({7'h0, alarm_flag_o}, 8'h00);
      $display("test alarm_flag done");
      summarize();
   end
endmodule : test_rtc_serial_slave_alarm_regs

// ===== hw/rtc_alarm_slave.sv
// two-wire slave end with the alarm match registers and the alarm flag
//
// Notes on behaviour
// [RQ1] bit 7 low enables the field match
// [RQ2] minute match at 09H, BCD 00-59
// [RQ3] hour match at 0AH, BCD, bit 6 unused
// [RQ4] day match at 0BH, BCD 01-31
// [RQ5] weekday match at 0CH, bits 2:0 only
// [RQ6] master starts only on an idle bus
// [RQ7] data changes only while clock low
// [RQ8] falling data with clock high starts
// [RQ9] rising data with clock high stops
// [RQ10] master chooses the byte count freely
// [RQ11] ninth clock carries the receiver acknowledge
// [RQ12] addressed receiver pulls data low on acknowledge
// [RQ13] bytes travel most significant bit first
// [RQ14] master leaves last read byte unacknowledged
// [RQ15] repeated start replaces stop
// [RQ16] address 1010001 plus direction, match only
// [RQ17] first written byte loads the pointer
// [RQ18] later written bytes stored and acknowledged
// [RQ19] read direction sends from the pointer
// [RQ20] read without new pointer reuses old pointer
// [RQ21] not-acknowledge ends sending, data released
// [RQ22] pointer advances after every data byte
// [RQ23] foreign address ignored until start or stop
// [RQ24] alarm flag set by hardware, cleared only
//
// Added by the designer: link commands issued over Wishbone in rtc_link_master.
`timescale 1ns/1ps
module rtc_alarm_slave
   import rtc_link_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic alarm_fire_i,
   output logic [7:0] minute_match_o,
   output logic [7:0] hour_match_o,
   output logic [7:0] day_of_month_match_o,
   output logic [7:0] weekday_match_o,
   output logic alarm_flag_o,
   rtc_link_if.dev link
);

   // ------------
   // state
   // ------------
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      dev_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      byte_kind_t kind;
      logic rd;
      logic [3:0] ptr;
      logic oe;
      logic mack;
      logic alarm_flag;
      logic [3:0][7:0] alarm;
   } dev_regs_t;

   dev_regs_t q;
   dev_regs_t next_q;

   // register read decode; unmapped pointers read as zero
   function automatic logic [7:0] reg_read(input dev_regs_t s, input logic [3:0] p);
      logic [3:0] idx;
      logic [7:0] r;
      idx = p - REG_MIN_ALARM;
      r = 8'h00;
      if (p == REG_STATUS2) begin
         r[ALARM_FLAG_BIT] = s.alarm_flag;
      end else if (p >= REG_MIN_ALARM && p <= REG_WDAY_ALARM) begin
         r = s.alarm[idx[1:0]];
      end
      return r;
   endfunction : reg_read

   // ------------
   // next-state logic
   // ------------
   always_comb begin
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [3:0] idx;
      logic [7:0] tx;
      scl = 1'b0;
      sda = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      idx = 4'h0;
      tx = 8'h00;
      next_q = q;

      // two-stage synchronisers; edges are found on the second stage only
      next_q.scl_s = {q.scl_s[0], link.scl};
      next_q.sda_s = {q.sda_s[0], link.sda};
      next_q.scl_d = q.scl_s[1];
      next_q.sda_d = q.sda_s[1];
      scl = q.scl_s[1];
      sda = q.sda_s[1];
      rise = scl & ~q.scl_d;
      fall = ~scl & q.scl_d;
      start = scl & q.scl_d & q.sda_d & ~sda; // RQ8
      stop = scl & q.scl_d & ~q.sda_d & sda; // RQ9

      // start and stop win over any byte in flight, so a repeated
      // start simply restarts the address phase
      if (start) begin
         next_q.st = D_RECV; // RQ15
         next_q.cnt = 4'h0;
         next_q.kind = K_ADDR;
         next_q.oe = 1'b0;
      end else if (stop) begin
         next_q.st = D_IDLE;
         next_q.oe = 1'b0;
      end else begin
         case (q.st)
            // sample on clock rise; data is only valid while clock high
            D_RECV: begin
               if (rise && q.cnt < 4'h8) begin
                  next_q.sh = {q.sh[6:0], sda}; // RQ13 RQ7
                  next_q.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt == 4'h8) begin
                  case (q.kind)
                     K_ADDR: begin
                        if (q.sh[7:1] == DEV_ADDR) begin // RQ16
                           next_q.rd = q.sh[0];
                           next_q.oe = 1'b1; // RQ12
                           next_q.st = D_ACK;
                        end else begin
                           next_q.st = D_IGNORE; // RQ23
                        end
                     end
                     K_PTR: begin
                        next_q.ptr = q.sh[3:0]; // RQ17
                        next_q.oe = 1'b1; // RQ12
                        next_q.st = D_ACK;
                     end
                     default: begin
                        if (q.ptr == REG_STATUS2) begin
                           // writing 0 clears the flag, writing 1 leaves it
                           if (!q.sh[ALARM_FLAG_BIT]) begin
                              next_q.alarm_flag = 1'b0; // RQ24
                           end
                        end else if (q.ptr >= REG_MIN_ALARM && q.ptr <= REG_WDAY_ALARM) begin
                           idx = q.ptr - REG_MIN_ALARM;
                           // unused bits are not stored and read back as 0
                           next_q.alarm[idx[1:0]] = q.sh & ALARM_MASK[idx[1:0]]; // RQ18 RQ3 RQ5
                        end
                        next_q.ptr = q.ptr + 4'h1; // RQ22
                        next_q.oe = 1'b1; // RQ12
                        next_q.st = D_ACK;
                     end
                  endcase
               end
            end
            // hold the acknowledge low for the whole ninth clock
            D_ACK: begin
               if (fall) begin // RQ11
                  next_q.cnt = 4'h0;
                  if (q.rd && q.kind == K_ADDR) begin
                     tx = reg_read(q, q.ptr); // RQ19 RQ20
                     next_q.sh = tx;
                     next_q.ptr = q.ptr + 4'h1; // RQ22
                     next_q.oe = ~tx[7]; // RQ13
                     next_q.st = D_SEND;
                  end else begin
                     next_q.oe = 1'b0;
                     next_q.kind = (q.kind == K_ADDR) ? K_PTR : K_DATA;
                     next_q.st = D_RECV;
                  end
               end
            end
            // change data only just after the clock falls
            D_SEND: begin
               if (fall) begin // RQ7
                  if (q.cnt == 4'h7) begin
                     next_q.oe = 1'b0;
                     next_q.mack = 1'b0;
                     next_q.st = D_MACK;
                  end else begin
                     next_q.cnt = q.cnt + 4'h1;
                     next_q.sh = {q.sh[6:0], 1'b0};
                     next_q.oe = ~q.sh[6]; // RQ13
                  end
               end
            end
            // master acknowledge: low means send on, high means finish
            D_MACK: begin
               if (rise) begin
                  next_q.mack = ~sda;
               end else if (fall) begin
                  if (q.mack) begin
                     tx = reg_read(q, q.ptr);
                     next_q.sh = tx;
                     next_q.ptr = q.ptr + 4'h1; // RQ22
                     next_q.cnt = 4'h0;
                     next_q.oe = ~tx[7];
                     next_q.st = D_SEND;
                  end else begin
                     next_q.st = D_IGNORE; // RQ21
                  end
               end
            end
            default: begin
               next_q.oe = 1'b0;
            end
         endcase
      end

      // a fresh alarm event beats a clear in the same cycle
      if (alarm_fire_i) begin
         next_q.alarm_flag = 1'b1; // RQ24
      end
   end

   // ------------
   // registers
   // ------------
   // synchronisers reset high so an idle bus shows no false edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.scl_s <= 2'b11;
         q.sda_s <= 2'b11;
         q.scl_d <= 1'b1;
         q.sda_d <= 1'b1;
         q.st <= D_IDLE;
         q.kind <= K_ADDR;
         q.alarm <= {4{ALARM_RESET}}; // RQ1
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   // ------------
   // outputs
   // ------------
   // match values keep bit 7 as the field disable; 0 means compared
   assign minute_match_o = q.alarm[0]; // RQ2 RQ1
   assign hour_match_o = q.alarm[1];
   assign day_of_month_match_o = q.alarm[2]; // RQ4
   assign weekday_match_o = q.alarm[3];
   assign alarm_flag_o = q.alarm_flag;
   assign link.dev_sda_o = 1'b0; // open drain: only ever pulls low
   assign link.dev_sda_oe = q.oe;

endmodule : rtc_alarm_slave

// ===== hw/rtc_link_if.sv
// two-wire link between the controller and the alarm-register device
`timescale 1ns/1ps
interface rtc_link_if;
   logic host_scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // open-drain data line: low while any enabled driver pulls low
   assign scl = host_scl;
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input sda, output host_scl, output host_sda_o, output host_sda_oe);
endinterface : rtc_link_if

// ===== hw/rtc_link_master.sv
// two-wire bus master end, commanded over a classic wishbone slave port
`timescale 1ns/1ps
module rtc_link_master
   import rtc_link_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   rtc_link_if.host link
);

   // ------------
   // state
   // ------------
   typedef struct packed {
      logic [1:0] sda_s;
      host_state_t st;
      logic [1:0] ph;
      logic [6:0] tick;
      logic [3:0] bitn;
      logic [7:0] tx;
      logic [7:0] rx;
      logic do_stop;
      logic rd;
      logic nack_send;
      logic busy;
      logic nack_seen;
      logic holds;
      logic scl;
      logic oe;
      logic ack;
      logic [31:0] dat;
   } host_regs_t;

   host_regs_t q;
   host_regs_t next_q;

   // ------------
   // next-state logic
   // ------------
   always_comb begin
      logic sda;
      logic step;
      sda = q.sda_s[1];
      step = 1'b0;
      next_q = q;
      next_q.sda_s = {q.sda_s[0], link.sda};

      // one bit is four quarter periods of the divided clock
      if (q.st != H_IDLE) begin
         step = (q.tick == QUARTER_CYC - 7'd1);
         next_q.tick = step ? 7'd0 : q.tick + 7'd1;
      end

      case (q.st)
         H_START: begin
            // wait for an idle bus unless we already own it
            if (step && (q.holds || q.ph != 2'd0 || sda)) begin // RQ6
               next_q.ph = q.ph + 2'd1;
               case (q.ph)
                  2'd0: next_q.oe = 1'b0;
                  2'd1: next_q.scl = 1'b1;
                  2'd2: next_q.oe = 1'b1; // RQ8 RQ15
                  default: begin
                     next_q.scl = 1'b0;
                     next_q.holds = 1'b1;
                     next_q.st = H_BIT;
                  end
               endcase
            end
         end
         H_BIT: begin
            if (step) begin
               next_q.ph = q.ph + 2'd1;
               case (q.ph)
                  // data set up while the clock is low
                  2'd0: begin // RQ7
                     if (q.bitn < 4'd8) begin
                        next_q.oe = q.rd ? 1'b0 : ~q.tx[7]; // RQ13
                     end else begin
                        next_q.oe = q.rd ? ~q.nack_send : 1'b0; // RQ11 RQ14
                     end
                  end
                  2'd1: next_q.scl = 1'b1;
                  2'd2: begin
                     if (q.bitn < 4'd8 && q.rd) begin
                        next_q.rx = {q.rx[6:0], sda};
                     end else if (q.bitn == 4'd8 && !q.rd) begin
                        next_q.nack_seen = sda;
                     end
                  end
                  default: begin
                     next_q.scl = 1'b0;
                     next_q.tx = {q.tx[6:0], 1'b0};
                     next_q.bitn = q.bitn + 4'd1;
                     if (q.bitn == 4'd8) begin
                        next_q.bitn = 4'd0;
                        if (q.do_stop) begin
                           next_q.st = H_STOP;
                        end else begin
                           next_q.st = H_IDLE;
                           next_q.busy = 1'b0;
                        end
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (step) begin
               next_q.ph = q.ph + 2'd1;
               case (q.ph)
                  2'd0: next_q.oe = 1'b1;
                  2'd1: next_q.scl = 1'b1;
                  2'd2: next_q.oe = 1'b0; // RQ9
                  default: begin
                     next_q.st = H_IDLE;
                     next_q.busy = 1'b0;
                     next_q.holds = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            next_q.tick = 7'd0;
            next_q.ph = 2'd0;
         end
      endcase

      // wishbone: one-cycle ack the cycle after the request is seen
      next_q.ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         next_q.ack = 1'b1;
         next_q.dat = 32'h0000_0000;
         if (wb_we_i) begin
            // a command while busy is dropped; status shows busy
            if (wb_adr_i == CTL_CMD_ADR && wb_sel_i[1:0] == 2'b11 && !q.busy) begin // RQ10
               next_q.tx = wb_dat_i[7:0];
               next_q.do_stop = wb_dat_i[CMD_STOP_BIT];
               next_q.rd = wb_dat_i[CMD_READ_BIT];
               next_q.nack_send = wb_dat_i[CMD_NACK_BIT];
               next_q.busy = 1'b1;
               next_q.bitn = 4'd0;
               next_q.ph = 2'd0;
               next_q.tick = 7'd0;
               next_q.st = wb_dat_i[CMD_START_BIT] ? H_START : H_BIT;
            end
         end else if (wb_adr_i == CTL_STATUS_ADR) begin
            next_q.dat = {16'h0000, q.rx, 5'h00, q.holds, q.nack_seen, q.busy};
         end
      end
   end

   // ------------
   // registers
   // ------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.sda_s <= 2'b11;
         q.scl <= 1'b1;
         q.st <= H_IDLE;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   // ------------
   // outputs
   // ------------
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign link.host_scl = q.scl;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = q.oe;

endmodule : rtc_link_master

// ===== hw/rtc_link_pkg.sv
// shared constants and types for the two-wire alarm-register link
package rtc_link_pkg;

   // ------------
   // timing
   // ------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCL_PERIOD_NS = 2500;
   localparam logic [6:0] QUARTER_CYC = 7'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));

   // ------------
   // device address and register map
   // ------------
   localparam logic [6:0] DEV_ADDR = 7'h51;
   localparam logic [3:0] REG_STATUS2 = 4'h1;
   localparam logic [3:0] REG_MIN_ALARM = 4'h9;
   localparam logic [3:0] REG_HOUR_ALARM = 4'hA;
   localparam logic [3:0] REG_DAY_ALARM = 4'hB;
   localparam logic [3:0] REG_WDAY_ALARM = 4'hC;
   localparam int ALARM_FLAG_BIT = 3;
   localparam int FIELD_DISABLE_BIT = 7;
   localparam logic [7:0] ALARM_RESET = 8'h80;
   // writable bits of minute, hour, day, weekday match registers
   localparam logic [3:0][7:0] ALARM_MASK = {8'h87, 8'hBF, 8'hBF, 8'hFF};

   // ------------
   // controller register map (wishbone byte addresses)
   // ------------
   localparam logic [7:0] CTL_CMD_ADR = 8'h00;
   localparam logic [7:0] CTL_STATUS_ADR = 8'h04;
   localparam int CMD_START_BIT = 8;
   localparam int CMD_STOP_BIT = 9;
   localparam int CMD_READ_BIT = 10;
   localparam int CMD_NACK_BIT = 11;

   // ------------
   // state encodings
   // ------------
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_RECV = 3'b001,
      D_ACK = 3'b010,
      D_SEND = 3'b011,
      D_MACK = 3'b100,
      D_IGNORE = 3'b101
   } dev_state_t;

   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_PTR = 2'b01,
      K_DATA = 2'b10
   } byte_kind_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BIT = 2'b10,
      H_STOP = 2'b11
   } host_state_t;

endpackage : rtc_link_pkg
